/* fpdc_pkg.sv */
package fpdc_pkg;
  localparam int unsigned WORD_W         = 24;
  localparam int unsigned SEL_W          = 3;
  localparam int unsigned RATIO_W        = 7;
  localparam int unsigned DENOM_W        = 11;
  localparam int unsigned NUMER_W        = 11;
  localparam int unsigned CNT_W          = 5;

  // Register select codes in the low three bits of a word
  localparam logic [2:0]  SEL_WHOLE      = 3'h0;
  localparam logic [2:0]  SEL_DENOM      = 3'h1;
  localparam logic [2:0]  SEL_NUMER      = 3'h2;

  // Reset contents
  localparam logic [23:0] WHOLE_RST      = 24'h0001c0;
  localparam logic [23:0] DENOM_RST      = 24'h003001;
  localparam logic [23:0] NUMER_RST      = 24'h001802;

  // Field positions
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned RATIO_LSB      = 3;
  localparam int unsigned DIV_SEL_BIT    = 10;
  localparam int unsigned DENOM_LSB      = 3;
  localparam int unsigned NUMER_LSB      = 3;

  localparam logic [4:0]  WORD_BITS      = 5'h18;
endpackage : fpdc_pkg

/* fpdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pins from outside the sys_clk domain
module fpdc_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule : fpdc_sync
`default_nettype wire

/* fpdc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - Select 000 loads whole-ratio register, default 0x0001C0
// RULE2 - Bit 10: 0 fractional, 1 integer
// RULE3 - Host keeps integer-mode ratio 21..123
// RULE4 - Host keeps fractional-mode ratio 24..119
// RULE5 - Ratio is seven bits, bits 9..3
// RULE6 - Integer mode: fvco = 2*fpfd*ratio
// RULE7 - Fractional: fvco = 2*fpfd*(ratio+num/den)
// RULE8 - Select 001 loads denominator, default 0x003001
// RULE9 - Denominator eleven bits from bit 3, 1..2047
// RULE10 - Select 010 loads numerator, default 0x001802
// RULE11 - Host keeps numerator below denominator
// RULE12 - 24-bit words over three-wire serial port
// RULE13 - Host first writes registers 7 down to 0
// RULE14 - Reserved upper bits stored, otherwise ignored
// RULE15 - Only complete 24-bit words update registers
module fpdc_regs
  import fpdc_pkg::*;
#(
  parameter int unsigned WORD_LEN = 24
) (
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  input  wire logic                 ser_clk,
  input  wire logic                 ser_data,
  input  wire logic                 ser_le,
  output logic [fpdc_pkg::WORD_W-1:0]  whole_ratio_divide_ctrl,
  output logic [fpdc_pkg::WORD_W-1:0]  fraction_denominator_ctrl,
  output logic [fpdc_pkg::WORD_W-1:0]  fraction_numerator_ctrl,
  output logic [fpdc_pkg::RATIO_W-1:0] whole_ratio_bits,
  output logic                      divider_select_bit,
  output logic [fpdc_pkg::DENOM_W-1:0] denominator_value,
  output logic [fpdc_pkg::NUMER_W-1:0] numerator_value,
  output logic                      word_loaded,
  output logic [fpdc_pkg::SEL_W-1:0]   other_reg_sel,
  output logic                      other_reg_load,
  output logic [fpdc_pkg::WORD_W-1:0]  other_reg_word
);
  import fpdc_pkg::*;

  logic [2:0] pins_s;
  logic       clk_s;
  logic       dat_s;
  logic       le_s;

  fpdc_sync #(.W(3)) u_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in ({ser_clk, ser_data, ser_le}),
    .sync_out (pins_s)
  );

  assign clk_s = pins_s[2];
  assign dat_s = pins_s[1];
  assign le_s  = pins_s[0];

  // Frame tracking: latched, shifting, or overlong and spoilt
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DROP  = 3'b100
  } fpdc_frame_t;

  // Register select code carried in a received word
  function automatic logic [SEL_W-1:0] word_sel(
    input logic [WORD_W-1:0] w
  );
    return w[SEL_LSB +: SEL_W];
  endfunction : word_sel

  // Framing state
  fpdc_frame_t       state_r;
  fpdc_frame_t       state_nxt;
  logic              clk_d_r;
  logic              clk_d_nxt;
  logic              clk_rise;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              word_full;
  logic              word_done;

  // Register state
  logic [WORD_W-1:0] whole_r;
  logic [WORD_W-1:0] whole_nxt;
  logic [WORD_W-1:0] denom_r;
  logic [WORD_W-1:0] denom_nxt;
  logic [WORD_W-1:0] numer_r;
  logic [WORD_W-1:0] numer_nxt;
  logic              loaded_r;
  logic              loaded_nxt;
  logic [SEL_W-1:0]  osel_r;
  logic [SEL_W-1:0]  osel_nxt;
  logic              oload_r;
  logic              oload_nxt;
  logic [WORD_W-1:0] oword_r;
  logic [WORD_W-1:0] oword_nxt;

  assign clk_rise  = clk_s & ~clk_d_r;
  assign word_full = (cnt_r == WORD_LEN[CNT_W-1:0]);
  // Commit only on latch rise after exactly one full word
  assign word_done = (state_r == ST_SHIFT) && le_s && word_full; // RULE15 RULE12

  always_comb begin
    state_nxt = state_r;
    clk_d_nxt = clk_s;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = '0;
        if (!le_s) begin
          state_nxt = ST_SHIFT;
          if (clk_rise) begin
            shift_nxt = {shift_r[WORD_W-2:0], dat_s}; // RULE12
            cnt_nxt   = 5'h01;
          end
        end
      end
      ST_SHIFT: begin
        if (le_s) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end else if (clk_rise) begin
          if (word_full) begin
            // One bit too many spoils the word
            state_nxt = ST_DROP; // RULE15
          end else begin
            // MSB first into a 24-bit word
            shift_nxt = {shift_r[WORD_W-2:0], dat_s}; // RULE12
            cnt_nxt   = cnt_r + 5'h01;
          end
        end
      end
      ST_DROP: begin
        if (le_s) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      clk_d_r <= 1'b0;
      shift_r <= '0;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      clk_d_r <= clk_d_nxt;
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_comb begin
    whole_nxt  = whole_r;
    denom_nxt  = denom_r;
    numer_nxt  = numer_r;
    loaded_nxt = 1'b0;
    oload_nxt  = 1'b0;
    osel_nxt   = osel_r;
    oword_nxt  = oword_r;
    if (word_done) begin
      loaded_nxt = 1'b1;
      case (word_sel(shift_r))
        SEL_WHOLE: whole_nxt = shift_r; // RULE1 RULE14
        SEL_DENOM: denom_nxt = shift_r; // RULE8 RULE14
        SEL_NUMER: numer_nxt = shift_r; // RULE10 RULE14
        default: begin
          oload_nxt = 1'b1;
          osel_nxt  = word_sel(shift_r);
          oword_nxt = shift_r;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      whole_r  <= WHOLE_RST;
      denom_r  <= DENOM_RST;
      numer_r  <= NUMER_RST;
      loaded_r <= 1'b0;
      osel_r   <= '0;
      oload_r  <= 1'b0;
      oword_r  <= '0;
    end else begin
      whole_r  <= whole_nxt;
      denom_r  <= denom_nxt;
      numer_r  <= numer_nxt;
      loaded_r <= loaded_nxt;
      osel_r   <= osel_nxt;
      oload_r  <= oload_nxt;
      oword_r  <= oword_nxt;
    end
  end

  assign whole_ratio_divide_ctrl   = whole_r;
  assign fraction_denominator_ctrl = denom_r;
  assign fraction_numerator_ctrl   = numer_r;
  // Fields handed to the synthesizer divider
  assign whole_ratio_bits   = whole_r[RATIO_LSB +: RATIO_W]; // RULE5 RULE6
  assign divider_select_bit = whole_r[DIV_SEL_BIT]; // RULE2 RULE7
  assign denominator_value  = denom_r[DENOM_LSB +: DENOM_W]; // RULE9 RULE7
  assign numerator_value    = numer_r[NUMER_LSB +: NUMER_W]; // RULE7
  assign word_loaded        = loaded_r;
  assign other_reg_sel      = osel_r;
  assign other_reg_load     = oload_r;
  assign other_reg_word     = oword_r;
endmodule : fpdc_regs
`default_nettype wire

/* fpdc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fpdc_monitor (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        ser_le,
  input wire logic        word_loaded,
  input wire logic        divider_select_bit,
  input wire logic [6:0]  whole_ratio_bits,
  input wire logic [10:0] denominator_value,
  input wire logic [23:0] whole_ratio_divide_ctrl,
  input wire logic [23:0] fraction_denominator_ctrl,
  input wire logic [23:0] fraction_numerator_ctrl,
  input wire logic        other_reg_load,
  input wire logic [2:0]  other_reg_sel,
  input wire logic [23:0] other_reg_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_ratio_field: assert property (
    whole_ratio_bits == whole_ratio_divide_ctrl[9:3]) else $error("ratio");
  chk_mode_bit: assert property (
    divider_select_bit == whole_ratio_divide_ctrl[10]) else $error("mode");
  chk_denom_field: assert property (
    denominator_value == fraction_denominator_ctrl[13:3]) else $error("den");
  chk_whole_load: assert property (
    $changed(whole_ratio_divide_ctrl) |->
      word_loaded && whole_ratio_divide_ctrl[2:0] == 3'h0) else $error("r0");
  chk_denom_load: assert property (
    $changed(fraction_denominator_ctrl) |->
      word_loaded && fraction_denominator_ctrl[2:0] == 3'h1) else $error("r1");
  chk_numer_load: assert property (
    $changed(fraction_numerator_ctrl) |->
      word_loaded && fraction_numerator_ctrl[2:0] == 3'h2) else $error("r2");
  chk_commit_after_le: assert property (
    word_loaded |-> $past(ser_le, 2)) else $error("le");
  chk_pulse_once: assert property (
    word_loaded |=> !word_loaded) else $error("pulse");
  chk_other_route: assert property (
    other_reg_load |-> word_loaded && other_reg_sel > 3'h2 &&
      other_reg_sel == other_reg_word[2:0]) else $error("other");
  chk_load_latched: assert property (
    word_loaded |-> ser_le) else $error("latch");
  cover property (word_loaded && divider_select_bit);
  cover property ($changed(fraction_denominator_ctrl));
  cover property ($changed(fraction_numerator_ctrl));
  cover property (other_reg_load);
endmodule : fpdc_monitor
bind fpdc_regs fpdc_monitor fpdc_monitor_i (.*);
`default_nettype wire

/* fpdc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fpdc_host (
  input  wire logic sys_clk,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_le
);
  initial {ser_clk, ser_data, ser_le} = 3'h1;
  // Clock idles low; data flips once deselected
  task automatic send(input logic [23:0] w, input int n);
    ser_le <= 1'b0;
    for (int k = 0; k < n; k++) begin
      ser_data <= w[23 - k % 24];
      repeat (4) @(posedge sys_clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    ser_le   <= 1'b1;
    ser_data <= ~ser_data;
    repeat (8) @(posedge sys_clk);
  endtask : send
endmodule : fpdc_host
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        ser_clk, ser_data, ser_le, dm;
  logic [6:0]  ratio;
  logic [10:0] den, num;
  logic [23:0] w0, w1, w2, oword;
  logic        wl, ol;
  logic [2:0]  osel;
  int          n_wl = 0;
  int          n_ol = 0;
  int          errors = 0;
  int          checks_done = 0;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  always #12.5 sys_clk = ~sys_clk;
  // Count the one-cycle commit pulses
  always @(posedge sys_clk) begin
    if (wl === 1'b1) n_wl <= n_wl + 1;
    if (ol === 1'b1) n_ol <= n_ol + 1;
  end
  fpdc_host fpdc_host_i (.sys_clk(sys_clk), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_le(ser_le));
  fpdc_regs fpdc_regs_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
    .whole_ratio_divide_ctrl(w0), .fraction_denominator_ctrl(w1),
    .fraction_numerator_ctrl(w2), .whole_ratio_bits(ratio),
    .divider_select_bit(dm), .denominator_value(den),
    .numerator_value(num), .word_loaded(wl), .other_reg_sel(osel),
    .other_reg_load(ol), .other_reg_word(oword));
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK({w0, w1, w2}, {24'h0001c0, 24'h003001, 24'h001802})
    `CHK({dm, ratio, den, num}, {1'b0, 7'h38, 11'h600, 11'h300})
    $display("reset test done");
    for (int r = 7; r > 2; r--) fpdc_host_i.send(24'h00a5f8 | 24'(r), 24);
    fpdc_host_i.send(24'h003ff2, 24);
    fpdc_host_i.send(24'h003ff9, 24);
    fpdc_host_i.send(24'h0007d8, 24);
    `CHK({w0, w1, w2}, {24'h0007d8, 24'h003ff9, 24'h003ff2})
    `CHK({dm, ratio, den, num}, {1'b1, 7'h7b, 11'h7ff, 11'h7fe})
    `CHK({n_wl, n_ol}, {32'd8, 32'd5})
    `CHK({osel, oword}, {3'h3, 24'h00a5fb})
    $display("setup test done");
    fpdc_host_i.send(24'h8000c0, 24);
    `CHK({w0, dm, ratio}, {24'h8000c0, 1'b0, 7'h18})
    fpdc_host_i.send(24'h0007d8, 23);
    fpdc_host_i.send(24'h0007d8, 25);
    `CHK(w0, 24'h8000c0)
    `CHK({n_wl, n_ol}, {32'd9, 32'd5})
    $display("framing test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK({w0, w1, w2}, {24'h0001c0, 24'h003001, 24'h001802})
    `CHK({osel, oword, wl}, 28'h0)
    fpdc_host_i.send(24'h000388, 24);
    `CHK({w0, dm, ratio}, {24'h000388, 1'b0, 7'h71})
    $display("mid-run reset test done");
    summarize();
  end
endmodule : tb
`default_nettype wire
